/* File: rtl/cacpw_defs.vh */
`ifndef CACPW_DEFS_VH
`define CACPW_DEFS_VH
// ----------------------------------------
// Mode register field positions
// ----------------------------------------
`define CACPW_MODE_IRQ_EN 0
`define CACPW_MODE_PWM 1
`define CACPW_MODE_MATCH_EN 3
`define CACPW_MODE_COMPARE_EN 6
// ----------------------------------------
// Reset values and watchdog module index
// ----------------------------------------
`define CACPW_MODE_RESET 8'h00
`define CACPW_BYTE_RESET 8'h00
`define CACPW_COUNT_RESET 16'h0000
`define CACPW_WDOG_MODULE 4
`endif

/* File: rtl/cacpw_module.v */
`timescale 1ns/1ps
`default_nettype none
`include "cacpw_defs.vh"
module cacpw_module #(
    parameter WDOG_CAPABLE = 0
) (
    input wire clk_in,
    input wire srst_in,
    input wire [15:0] count_in,
    input wire tick_in,
    input wire mode_wr_in,
    input wire low_wr_in,
    input wire high_wr_in,
    input wire [7:0] wdata_in,
    input wire flag_clr_in,
    input wire flag_set_in,
    input wire watchdog_enable_in,
    output wire [7:0] mode_out,
    output wire [7:0] low_out,
    output wire [7:0] high_out,
    output wire flag_out,
    output wire irq_out,
    output wire pwm_out,
    output wire wdog_hit_out
);
    reg [7:0] mode_reg;
    reg [7:0] low_reg;
    reg [7:0] high_reg;
    reg flag_reg;
    reg pwm_reg;
    wire compare_enable = mode_reg[`CACPW_MODE_COMPARE_EN];
    wire match_enable = mode_reg[`CACPW_MODE_MATCH_EN];
    wire pwm_mode = mode_reg[`CACPW_MODE_PWM] & compare_enable; // see [R11]
    wire match = compare_enable & match_enable & tick_in &
        (count_in == {high_reg, low_reg}); // see [R1]
    wire wdog_on = (WDOG_CAPABLE != 0) & watchdog_enable_in; // see [R12] see [R15]
    wire [7:0] next_low = count_in[7:0] + 8'h01;
    // ----------------------------------------
    // Mode, compare bytes, flag
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (srst_in) begin
            mode_reg <= `CACPW_MODE_RESET;
            low_reg <= `CACPW_BYTE_RESET;
            high_reg <= `CACPW_BYTE_RESET;
            flag_reg <= 1'b0;
            pwm_reg <= 1'b0;
        end else begin
            if (mode_wr_in) begin
                mode_reg <= wdata_in; // see [R5]
            end else if (low_wr_in) begin
                mode_reg[`CACPW_MODE_COMPARE_EN] <= 1'b0; // see [R3]
            end else if (high_wr_in) begin
                mode_reg[`CACPW_MODE_COMPARE_EN] <= 1'b1; // see [R4]
            end
            if (low_wr_in) begin
                low_reg <= wdata_in;
            end else if (pwm_mode && tick_in && next_low == 8'h00) begin
                low_reg <= high_reg; // see [R10]
            end
            if (high_wr_in) begin
                high_reg <= wdata_in;
            end
            if (match || flag_set_in) begin
                flag_reg <= 1'b1; // see [R17]
            end else if (flag_clr_in) begin
                flag_reg <= 1'b0;
            end
            if (!pwm_mode) begin
                pwm_reg <= 1'b0;
            end else begin
                pwm_reg <= (count_in[7:0] >= low_reg); // see [R9] see [R8]
            end
        end
    end
    assign mode_out = mode_reg;
    assign low_out = low_reg;
    assign high_out = high_reg;
    assign flag_out = flag_reg;
    assign irq_out = flag_reg & mode_reg[`CACPW_MODE_IRQ_EN]; // see [R2]
    assign pwm_out = pwm_reg;
    assign wdog_hit_out = match & wdog_on; // see [R13]
endmodule
`default_nettype wire

/* File: rtl/cacpw_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "cacpw_defs.vh"
// Function
// [R1] Compare counter to module value when compare and match enables set
// [R2] Interrupt requested only when event flag and module interrupt enable both set
// [R3] Writing compare low byte clears compare enable
// [R4] Writing compare high byte sets compare enable
// [R5] Compare enable stays directly writable through mode register
// [R6] Software writes low byte first then high byte
// [R7] Software loads nonzero compare value before enabling comparison
// [R8] PWM modules share counter frequency, each with own duty byte
// [R9] PWM output low below duty byte, high at or above
// [R10] Duty byte reloads from high byte when counter low byte wraps
// [R11] PWM active only with PWM select and compare enable set
// [R12] Only module four can be watchdog, other modes still available
// [R13] Watchdog match generates internal reset
// [R14] Internal reset never drives external reset pin
// [R15] Clearing watchdog enable disables reset, setting re-enables it
// [R16] Software changes compare or counter periodically to avoid reset
// [R17] Event flag set by hardware on match, cleared by software
// [R18] Counter counts only while run bit set
// [R19] Counter increments per tick, wrapping from all ones to zero
module cacpw_top #(
    parameter NUM_MODULES = 5
) (
    input wire clk_in,
    input wire srst_in,
    input wire tick_in,
    input wire counter_run_in,
    input wire count_wr_low_in,
    input wire count_wr_high_in,
    input wire watchdog_enable_in,
    input wire [NUM_MODULES-1:0] mode_wr_in,
    input wire [NUM_MODULES-1:0] low_wr_in,
    input wire [NUM_MODULES-1:0] high_wr_in,
    input wire [NUM_MODULES-1:0] flag_clr_in,
    input wire [NUM_MODULES-1:0] flag_set_in,
    input wire [7:0] wdata_in,
    output wire [15:0] count_out,
    output wire [8*NUM_MODULES-1:0] mode_out,
    output wire [8*NUM_MODULES-1:0] low_out,
    output wire [8*NUM_MODULES-1:0] high_out,
    output wire [NUM_MODULES-1:0] module_event_flag_out,
    output wire [NUM_MODULES-1:0] irq_out,
    output wire [NUM_MODULES-1:0] pwm_out,
    output wire internal_reset_out,
    output wire rst_pin_oe_out
);
    reg [15:0] count_reg;
    reg wdog_reset_reg;
    wire run_tick = tick_in & counter_run_in; // see [R18]
    wire [NUM_MODULES-1:0] hit;
    // ----------------------------------------
    // Shared counter
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (srst_in) begin
            count_reg <= `CACPW_COUNT_RESET;
            wdog_reset_reg <= 1'b0;
        end else begin
            if (count_wr_low_in) begin
                count_reg[7:0] <= wdata_in;
            end else if (count_wr_high_in) begin
                count_reg[15:8] <= wdata_in;
            end else if (run_tick) begin
                count_reg <= count_reg + 16'h0001; // see [R19]
            end
            wdog_reset_reg <= |hit; // see [R13]
        end
    end
    // ----------------------------------------
    // Compare modules
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_MODULES; i = i + 1) begin : g_mod
            cacpw_module #(
                .WDOG_CAPABLE(i == `CACPW_WDOG_MODULE)
            ) u_mod (
                .clk_in(clk_in),
                .srst_in(srst_in),
                .count_in(count_reg),
                .tick_in(run_tick),
                .mode_wr_in(mode_wr_in[i]),
                .low_wr_in(low_wr_in[i]),
                .high_wr_in(high_wr_in[i]),
                .wdata_in(wdata_in),
                .flag_clr_in(flag_clr_in[i]),
                .flag_set_in(flag_set_in[i]),
                .watchdog_enable_in(watchdog_enable_in),
                .mode_out(mode_out[8*i+7:8*i]),
                .low_out(low_out[8*i+7:8*i]),
                .high_out(high_out[8*i+7:8*i]),
                .flag_out(module_event_flag_out[i]),
                .irq_out(irq_out[i]),
                .pwm_out(pwm_out[i]),
                .wdog_hit_out(hit[i])
            );
        end
    endgenerate
    assign count_out = count_reg;
    assign internal_reset_out = wdog_reset_reg;
    assign rst_pin_oe_out = 1'b0; // see [R14]
endmodule
`default_nettype wire

/* File: testbench/cacpw_props_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cacpw_props #(parameter NUM_MODULES = 5) (
    input wire logic clk_in, srst_in, tick_in, counter_run_in, count_wr_low_in, count_wr_high_in,
    input wire logic watchdog_enable_in, internal_reset_out, rst_pin_oe_out,
    input wire logic [NUM_MODULES-1:0] mode_wr_in, low_wr_in, high_wr_in, flag_clr_in,
    input wire logic [NUM_MODULES-1:0] module_event_flag_out, irq_out, pwm_out,
    input wire logic [7:0] wdata_in,
    input wire logic [15:0] count_out,
    input wire logic [8*NUM_MODULES-1:0] mode_out, low_out, high_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire q = tick_in & counter_run_in & ~count_wr_low_in & ~count_wr_high_in;
    low_clr_a: assert property (low_wr_in[0] && !mode_wr_in[0] |=> !mode_out[6])
        else $error("enable kept");
    high_set_a: assert property (high_wr_in[0] && !mode_wr_in[0] && !low_wr_in[0] |=> mode_out[6])
        else $error("enable not set");
    mode_wr_a: assert property (mode_wr_in[0] && !low_wr_in[0] && !high_wr_in[0]
        |=> mode_out[7:0] == $past(wdata_in)) else $error("mode lost");
    irq_gate_a: assert property (irq_out[0] == (module_event_flag_out[0] && mode_out[0]))
        else $error("irq wrong");
    match_flag_a: assert property (q && mode_out[6] && mode_out[3] && !mode_out[1] &&
        count_out == {high_out[7:0], low_out[7:0]} |=> module_event_flag_out[0]) else $error("no flag");
    flag_hold_a: assert property (module_event_flag_out[0] && !flag_clr_in[0] |=>
        module_event_flag_out[0]) else $error("flag lost");
    count_stop_a: assert property (!counter_run_in && !count_wr_low_in && !count_wr_high_in |=>
        $stable(count_out)) else $error("count moved");
    count_inc_a: assert property (q |=> count_out == $past(count_out) + 16'h0001)
        else $error("bad step");
    pwm_off_a: assert property (!(mode_out[9] && mode_out[14]) |=> !pwm_out[1])
        else $error("pwm on");
    wdog_cause_a: assert property (internal_reset_out |-> $past(watchdog_enable_in && q))
        else $error("bad reset");
    pin_quiet_a: assert property (rst_pin_oe_out == 1'b0) else $error("pin driven");
    cover property (internal_reset_out);
    cover property (irq_out[0]);
    cover property (pwm_out[1]);
endmodule
bind cacpw_top cacpw_props #(.NUM_MODULES(NUM_MODULES)) PROPS(.*);
`default_nettype wire

/* File: testbench/cacpw_load.sv */
`timescale 1ns/1ps
`default_nettype none
module cacpw_load (
    input wire logic clk_in,
    input wire logic clr_in,
    input wire logic pwm_in,
    output logic [15:0] high_cnt_out
);
    // Load sees the pin and counts its high cycles
    always @(posedge clk_in) high_cnt_out <= clr_in ? 16'h0000 : high_cnt_out + {15'h0000, pwm_in};
endmodule
`default_nettype wire

/* File: testbench/cacpw_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cacpw_tb;
    logic clk_in, srst_in, tick_in, run, cwl, cwh, wde, clr;
    logic [4:0] mw, lw, hw, fc, fs;
    logic [7:0] wd;
    wire [15:0] cnt, hc;
    wire [39:0] mode, lo, hi;
    wire [4:0] flg, irq, pwm;
    wire ir, poe;
    int error_cnt, checks_done, rst_seen;
    cacpw_top DUT(.clk_in, .srst_in, .tick_in, .counter_run_in(run), .count_wr_low_in(cwl),
        .count_wr_high_in(cwh), .watchdog_enable_in(wde), .mode_wr_in(mw), .low_wr_in(lw),
        .high_wr_in(hw), .flag_clr_in(fc), .flag_set_in(fs), .wdata_in(wd), .count_out(cnt),
        .mode_out(mode), .low_out(lo), .high_out(hi), .module_event_flag_out(flg), .irq_out(irq),
        .pwm_out(pwm), .internal_reset_out(ir), .rst_pin_oe_out(poe));
    cacpw_load LOAD(.clk_in, .clr_in(clr), .pwm_in(pwm[1]), .high_cnt_out(hc));
    always @(posedge clk_in) if (ir) rst_seen++;
    initial begin
        clk_in = 0;
        forever #25 clk_in = ~clk_in;
    end
    task report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(string n, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(int k, int m, logic [7:0] d);
        @(posedge clk_in); #1;
        wd = d;
        case (k)
            0: mw[m] = 1;
            1: lw[m] = 1;
            2: hw[m] = 1;
            3: cwl = 1;
            default: cwh = 1;
        endcase
        @(posedge clk_in); #1;
        {mw, lw, hw, cwl, cwh} = 0;
    endtask
    task go(int n);
        @(posedge clk_in); #1 run = 1;
        repeat (n) @(posedge clk_in);
        #1 run = 0;
    endtask
    task ld(logic [15:0] v);
        wr(3, 0, v[7:0]);
        wr(4, 0, v[15:8]);
    endtask
    task t_cnt;
        ld(16'hFFFE);
        go(3);
        chk("count", 16'h0001, cnt);
        repeat (3) @(posedge clk_in);
        chk("count", 16'h0001, cnt);
        $display("count test done");
    endtask
    task t_cmp;
        ld(16'h1230);
        wr(1, 0, 8'h34);
        wr(2, 0, 8'h12);
        chk("enable", 1, mode[6]);
        wr(0, 0, 8'h09);
        chk("enable", 0, mode[6]);
        wr(0, 0, 8'h49);
        chk("enable", 1, mode[6]);
        wr(1, 0, 8'h34);
        chk("enable", 0, mode[6]);
        wr(2, 0, 8'h12);
        chk("enable", 1, mode[6]);
        go(8);
        chk("flag", 1, flg[0]);
        chk("irq", 1, irq[0]);
        wr(0, 0, 8'h48);
        chk("irq", 0, irq[0]);
        fc[0] = 1;
        @(posedge clk_in); #1 fc[0] = 0;
        chk("flag", 0, flg[0]);
        @(posedge clk_in); #1;
        fs[0] = 1;
        fc[0] = 1;
        @(posedge clk_in); #1 {fs, fc} = 0;
        chk("flag", 1, flg[0]);
        @(posedge clk_in); #1 fc[0] = 1;
        @(posedge clk_in); #1 fc[0] = 0;
        chk("flag", 0, flg[0]);
        $display("compare test done");
    endtask
    task t_pwm;
        wr(2, 1, 8'h40);
        wr(0, 1, 8'h42);
        run = 1;
        repeat (300) @(posedge clk_in);
        #1 clr = 1;
        @(posedge clk_in); #1 clr = 0;
        repeat (256) @(posedge clk_in);
        #1 run = 0;
        chk("duty", 16'h00C0, hc);
        chk("reload", 16'h0040, lo[15:8]);
        chk("high", 16'h0040, hi[15:8]);
        $display("pwm test done");
    endtask
    task t_wdog;
        wr(1, 4, 8'h10);
        wr(2, 4, 8'h00);
        wr(0, 4, 8'h48);
        ld(16'h0000);
        go(40);
        chk("wdog", 0, rst_seen);
        ld(16'h0000);
        wde = 1;
        go(12);
        ld(16'h0000);
        go(12);
        chk("wdog", 0, rst_seen);
        go(40);
        chk("wdog", 1, rst_seen);
        chk("pin", 0, poe);
        $display("watchdog test done");
    endtask
    initial begin
        {run, cwl, cwh, wde, clr, mw, lw, hw, fc, fs, wd} = 0;
        tick_in = 1;
        srst_in = 1;
        repeat (4) @(posedge clk_in);
        #1 srst_in = 0;
        t_cnt;
        t_cmp;
        t_pwm;
        t_wdog;
        report_and_stop;
    end
    initial begin
        #500000;
        error_cnt++;
        report_and_stop;
    end
endmodule
`default_nettype wire
